// ---- mcf_pkg.sv ----
// mcf_pkg: shared constants and types for the memory controller clock/cycle front
package mcf_pkg;

    // ------------------------------------------------------------
    // clocking figures
    // ------------------------------------------------------------
    localparam real XTAL_MHZ = 14.31818;      // crystal frequency
    localparam int OSC_DIVIDE = 12;           // slow clock ratio
    localparam int OSC_HALF = OSC_DIVIDE / 2; // crystal edges per half period
    localparam int CLOCK_MHZ = 125;           // processor clock rate

    // ------------------------------------------------------------
    // dram strobe timing, in processor clock cycles less one
    // ------------------------------------------------------------
    localparam logic [3:0] ROW_CYC = 4'h3;    // ras low before cas
    localparam logic [3:0] COL_CYC = 4'h4;    // cas low time
    localparam logic [3:0] PRE_CYC = 4'h3;    // ras precharge time
    localparam logic [3:0] ZERO4 = 4'h0;      // count floor

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;                   // cpu address width
    localparam int BANK_LSB = 21;                 // bank select low bit
    localparam int BANK_MSB = 22;                 // bank select high bit
    localparam int TOP_LSB = 16;                  // rom window compare low bit
    localparam logic [7:0] ROM_LOW_SEG = 8'h0f;   // bios below 1 mb
    localparam logic [7:0] ROM_HIGH_SEG = 8'hff;  // bios alias at top
    localparam logic [23:0] DRAM_TOP = 24'h800000; // end of on-board dram

    // ------------------------------------------------------------
    // configuration word
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_DEFAULT = 8'h03; // rom and dram enabled
    localparam int CFG_ROM_EN = 0;              // bios select enable bit
    localparam int CFG_DRAM_EN = 1;             // dram cycle enable bit

    // ------------------------------------------------------------
    // strobe idle levels
    // ------------------------------------------------------------
    localparam logic [3:0] RAS_IDLE = 4'hf;  // all row strobes high
    localparam logic [3:0] RAS_ALL = 4'h0;   // all row strobes low
    localparam logic [7:0] CAS_IDLE = 8'hff; // all column strobes high

    // cycle sequencer states, gray coded along the strobe path
    typedef enum logic [1:0] {
        MCF_IDLE = 2'b00,
        MCF_ROW = 2'b01,
        MCF_COL = 2'b11,
        MCF_PRE = 2'b10
    } mcf_cyc_t;

endpackage : mcf_pkg

// ---- mcf_sync.sv ----
// mcf_sync: two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module mcf_sync #(
    parameter int W = 8 // number of bits
) (
    input wire logic clock,         // processor clock
    input wire logic resetn,        // async reset, active low
    input wire logic [W-1:0] d_in,  // asynchronous pin levels
    output logic [W-1:0] q_out      // levels in the clock domain
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] meta; // first stage, read only by second
        logic [W-1:0] safe; // second stage
    } mcf_sync_t;

    mcf_sync_t st_reg;
    mcf_sync_t st_next;

    // next state: shift the pin levels through two stages
    always_comb begin
        st_next = st_reg;
        st_next.meta = d_in;
        st_next.safe = st_reg.meta;
    end

    // registers: constant on reset only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.safe;

endmodule : mcf_sync

// ---- mcf_front.sv ----
// mcf_front: clock, reset and cycle detection front of the dram controller
`timescale 1ns/1ps
module mcf_front (
    input wire logic clock,                  // processor clock
    input wire logic resetn,                 // async reset, active low
    input wire logic controller_reset_in,    // reset pin, active high
    input wire logic crystal_in,             // crystal pin level
    output logic crystal_out,                // crystal drive, inverted
    output logic system_oscillator_out,      // oscillator output
    output logic oscillator_div_twelve_out,  // oscillator divided by 12
    input wire logic refresh_n,              // refresh request, low
    input wire logic [1:0] status_n,         // cpu status, low
    input wire logic mem_io,                 // high memory, low io
    input wire logic [23:0] address,         // cpu local address
    input wire logic xbus_mem_read_n,        // xbus memory read, low
    input wire logic xbus_mem_write_n,       // xbus memory write, low
    input wire logic xbus_io_read_n,         // xbus io read, low
    input wire logic xbus_io_write,          // xbus io write, high
    input wire logic hold_ack_in,            // hold acknowledge, high
    input wire logic cfg_write,              // config load strobe
    input wire logic [7:0] cfg_data,         // config load value
    output logic [7:0] cfg_value,            // current configuration
    output logic [3:0] ras_n,                // row strobes, low
    output logic [7:0] cas_n,                // column strobes, low
    output logic bios_rom_select_n,          // bios eprom select, low
    output logic io_cycle                    // io cycle seen, high
);
    default clocking cb @(posedge clock); endclocking // checks sample here
    default disable iff (!resetn); // checks idle in async reset

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 11 + mcf_pkg::ADDR_W; // synchronised bits

    logic [NSYNC-1:0] pin_raw; // pins flipped: zero reset reads idle
    logic [NSYNC-1:0] pin_s;   // synchronised bundle
    localparam logic [NSYNC-1:0] PIN_IDLE = {5'h07, 1'b0, 3'h7, 26'h0}; // idle

    assign pin_raw = PIN_IDLE ^ {controller_reset_in, crystal_in,
        refresh_n, status_n, mem_io, xbus_mem_read_n, xbus_mem_write_n,
        xbus_io_read_n, xbus_io_write, hold_ack_in, address};

    // every pin but cfg_write and cfg_data takes two flops before the sequencer reads it
    mcf_sync #(.W(NSYNC)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .d_in(pin_raw),
        .q_out(pin_s)
    );

    logic rst_s;             // reset pin, synchronised
    logic xtal_s;            // crystal level
    logic ref_s_n;           // refresh, low
    logic [1:0] stat_s_n;    // status, low
    logic mio_s;             // memory/io
    logic mrd_s_n;           // xbus memory read
    logic mwr_s_n;           // xbus memory write
    logic ior_s_n;           // xbus io read
    logic iow_s;             // xbus io write
    logic hlda_s;            // hold acknowledge
    logic [23:0] addr_s;     // address

    assign {rst_s, xtal_s, ref_s_n, stat_s_n, mio_s, mrd_s_n, mwr_s_n,
        ior_s_n, iow_s, hlda_s, addr_s} = pin_s ^ PIN_IDLE;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic rom_hit;   // address in bios window
    logic dram_hit;  // address in on-board dram
    logic stat_act;  // a status line is low
    logic xmem_act;  // an xbus memory command is low
    logic xio_act;   // an xbus io command is active

    assign rom_hit = (addr_s[23:mcf_pkg::TOP_LSB] == mcf_pkg::ROM_LOW_SEG)
        || (addr_s[23:mcf_pkg::TOP_LSB] == mcf_pkg::ROM_HIGH_SEG);
    assign dram_hit = (addr_s < mcf_pkg::DRAM_TOP) && !rom_hit;
    assign stat_act = !stat_s_n[1] || !stat_s_n[0];
    assign xmem_act = !mrd_s_n || !mwr_s_n;
    assign xio_act = !ior_s_n || iow_s;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mcf_pkg::mcf_cyc_t cyc; // strobe sequencer
        logic [3:0] cnt;        // phase countdown
        logic [1:0] bank;       // bank of current cycle
        logic refr;             // current cycle is a refresh
        logic ref_d;            // refresh level last cycle
        logic stat_d;           // status activity last cycle
        logic xmem_d;           // xbus memory activity last cycle
        logic xtal_d;           // crystal level last cycle
        logic [3:0] div_cnt;    // crystal edge count
        logic div_out;          // divided clock
        logic osc_out;          // oscillator output
        logic xo_out;           // crystal drive
        logic [3:0] ras;        // row strobes
        logic [7:0] cas;        // column strobes
        logic rom_n;            // bios select
        logic io;               // io cycle flag
        logic [7:0] cfg;        // configuration word
    } mcf_state_t;

    mcf_state_t st_reg;
    mcf_state_t st_next;

    logic ref_start;   // refresh falling edge
    logic cpu_start;   // new cpu memory cycle to dram
    logic dma_start;   // new dma memory cycle to dram

    assign ref_start = !ref_s_n && st_reg.ref_d;
    assign cpu_start = stat_act && !st_reg.stat_d && mio_s && dram_hit
        && st_reg.cfg[mcf_pkg::CFG_DRAM_EN];
    assign dma_start = hlda_s && xmem_act && !st_reg.xmem_d && dram_hit
        && st_reg.cfg[mcf_pkg::CFG_DRAM_EN];

    // next state: oscillator, divider, strobe sequencer and rom select
    always_comb begin
        st_next = st_reg;
        st_next.xtal_d = xtal_s;
        st_next.ref_d = ref_s_n;
        st_next.stat_d = stat_act;
        st_next.xmem_d = xmem_act;
        if (rst_s) begin
            // reset parks everything and reloads defaults
            st_next.cyc = mcf_pkg::MCF_IDLE;
            st_next.cnt = mcf_pkg::ZERO4;
            st_next.refr = 1'b0;
            st_next.osc_out = 1'b0;
            st_next.xo_out = 1'b0;
            st_next.div_out = 1'b0;
            st_next.div_cnt = mcf_pkg::ZERO4;
            st_next.ras = mcf_pkg::RAS_IDLE;
            st_next.cas = mcf_pkg::CAS_IDLE;
            st_next.rom_n = 1'b1;
            st_next.io = 1'b0;
            st_next.cfg = mcf_pkg::CFG_DEFAULT;
        end else begin
            // the crystal is sampled, buffered out and inverted back
            st_next.osc_out = xtal_s;
            st_next.xo_out = !xtal_s;
            // count rising crystal edges, toggle every sixth one
            if (xtal_s && !st_reg.xtal_d) begin
                if (st_reg.div_cnt == 4'(mcf_pkg::OSC_HALF - 1)) begin
                    st_next.div_cnt = mcf_pkg::ZERO4;
                    st_next.div_out = !st_reg.div_out;
                end else begin
                    st_next.div_cnt = st_reg.div_cnt + 4'h1;
                end
            end
            if (cfg_write) begin
                st_next.cfg = cfg_data;
            end
            // io cycle flag follows status with memory/io low, or an xbus io command under hold
            st_next.io = (stat_act && !mio_s) || (hlda_s && xio_act);
            // bios select for cpu memory cycles or dma reads in window
            st_next.rom_n = !(st_reg.cfg[mcf_pkg::CFG_ROM_EN] && rom_hit
                && ((stat_act && mio_s) || (hlda_s && !mrd_s_n)));
            case (st_reg.cyc)
                mcf_pkg::MCF_IDLE: begin
                    // refresh wins over dma and cpu, which share one branch
                    if (ref_start) begin
                        st_next.refr = 1'b1;
                        st_next.ras = mcf_pkg::RAS_ALL;
                        st_next.cnt = mcf_pkg::ROW_CYC;
                        st_next.cyc = mcf_pkg::MCF_ROW;
                    end else if (dma_start || cpu_start) begin
                        st_next.refr = 1'b0;
                        st_next.bank = addr_s[mcf_pkg::BANK_MSB:
                            mcf_pkg::BANK_LSB];
                        st_next.ras = ~(4'h1 << addr_s[mcf_pkg::BANK_MSB:
                            mcf_pkg::BANK_LSB]);
                        st_next.cnt = mcf_pkg::ROW_CYC;
                        st_next.cyc = mcf_pkg::MCF_ROW;
                    end
                end
                mcf_pkg::MCF_ROW: begin
                    if (st_reg.cnt == mcf_pkg::ZERO4) begin
                        // refresh is ras-only: no column strobe
                        if (!st_reg.refr) begin
                            st_next.cas[{st_reg.bank, 1'b0} +: 2] = 2'b00;
                        end
                        st_next.cnt = mcf_pkg::COL_CYC;
                        st_next.cyc = mcf_pkg::MCF_COL;
                    end else begin
                        st_next.cnt = st_reg.cnt - 4'h1;
                    end
                end
                mcf_pkg::MCF_COL: begin
                    if (st_reg.cnt == mcf_pkg::ZERO4) begin
                        st_next.ras = mcf_pkg::RAS_IDLE;
                        st_next.cas = mcf_pkg::CAS_IDLE;
                        st_next.cnt = mcf_pkg::PRE_CYC;
                        st_next.cyc = mcf_pkg::MCF_PRE;
                    end else begin
                        st_next.cnt = st_reg.cnt - 4'h1;
                    end
                end
                mcf_pkg::MCF_PRE: begin
                    // precharge must finish before the next row strobe
                    if (st_reg.cnt == mcf_pkg::ZERO4) begin
                        st_next.refr = 1'b0;
                        st_next.cyc = mcf_pkg::MCF_IDLE;
                    end else begin
                        st_next.cnt = st_reg.cnt - 4'h1;
                    end
                end
                default: begin
                    st_next.cyc = mcf_pkg::MCF_IDLE;
                    st_next.ras = mcf_pkg::RAS_IDLE;
                    st_next.cas = mcf_pkg::CAS_IDLE;
                end
            endcase
        end
    end

    // registers on the processor clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{cyc: mcf_pkg::MCF_IDLE, ras: mcf_pkg::RAS_IDLE,
                cas: mcf_pkg::CAS_IDLE, rom_n: 1'b1,
                cfg: mcf_pkg::CFG_DEFAULT, ref_d: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, straight from flops
    // ------------------------------------------------------------
    assign crystal_out = st_reg.xo_out;
    assign system_oscillator_out = st_reg.osc_out;
    assign oscillator_div_twelve_out = st_reg.div_out;
    assign cfg_value = st_reg.cfg;
    assign ras_n = st_reg.ras;
    assign cas_n = st_reg.cas;
    assign bios_rom_select_n = st_reg.rom_n;
    assign io_cycle = st_reg.io;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_parks: assert property (rst_s |=>
        (ras_n == mcf_pkg::RAS_IDLE) && (cas_n == mcf_pkg::CAS_IDLE)
        && !system_oscillator_out && !oscillator_div_twelve_out)
        else $error("strobes or oscillator not parked in reset");
    a_reset_config: assert property (
        rst_s |=> cfg_value == mcf_pkg::CFG_DEFAULT)
        else $error("configuration not restored by reset");
    a_osc_follow: assert property (
        !rst_s |=> system_oscillator_out == $past(xtal_s))
        else $error("oscillator output does not follow crystal");
    a_div_toggle: assert property (
        $changed(oscillator_div_twelve_out) && !$past(rst_s)
        |-> $past(xtal_s && !st_reg.xtal_d)
        && $past(st_reg.div_cnt) == 4'(mcf_pkg::OSC_HALF - 1))
        else $error("divided clock toggled off the sixth edge");
    a_refresh_ras: assert property (
        ref_start && !rst_s && st_reg.cyc == mcf_pkg::MCF_IDLE
        |=> ras_n == mcf_pkg::RAS_ALL ##1 (ras_n == mcf_pkg::RAS_ALL)[*3])
        else $error("refresh did not drop all row strobes");
    a_refresh_nocas: assert property (
        st_reg.refr |-> cas_n == mcf_pkg::CAS_IDLE)
        else $error("column strobe during refresh");
    a_io_nostart: assert property (
        st_reg.cyc == mcf_pkg::MCF_IDLE && !mio_s && !hlda_s && !ref_start
        |=> ras_n == mcf_pkg::RAS_IDLE)
        else $error("io cycle started a dram strobe");
    a_dma_strobe: assert property (
        dma_start && !rst_s && !ref_start && st_reg.cyc == mcf_pkg::MCF_IDLE
        |=> ras_n != mcf_pkg::RAS_IDLE ##4 cas_n != mcf_pkg::CAS_IDLE)
        else $error("dma cycle missed its strobes");
    a_cpu_strobe: assert property (
        cpu_start && !dma_start && !rst_s && !ref_start
        && st_reg.cyc == mcf_pkg::MCF_IDLE
        |=> $countones(~ras_n) == 1)
        else $error("cpu cycle did not select one bank");
    a_rom_window: assert property (
        !bios_rom_select_n |-> $past(rom_hit))
        else $error("rom select outside bios window");

endmodule : mcf_front

// ---- mcf_cpu_model.sv ----
// mcf_cpu_model: cpu and bus controller side that drives the front's pins
`timescale 1ns/1ps
module mcf_cpu_model (
    input wire logic clock,          // processor clock
    output logic refresh_n,          // refresh request, low
    output logic [1:0] status_n,     // cpu status, low
    output logic mem_io,             // high memory, low io
    output logic [23:0] address,     // cpu local address
    output logic xbus_mem_read_n,    // dma memory read, low
    output logic xbus_mem_write_n,   // dma memory write, low
    output logic xbus_io_read_n,     // dma io read, low
    output logic xbus_io_write,      // dma io write, high
    output logic hold_ack_in         // hold acknowledge, high
);
    // ------------------------------------------------------------
    // idle levels: nothing requested, bus not held
    // ------------------------------------------------------------
    initial begin
        {refresh_n, status_n, xbus_mem_read_n, xbus_mem_write_n,
         xbus_io_read_n, xbus_io_write, hold_ack_in} = 8'hfc;
        mem_io = 1'b1;
        address = 24'h000000;
    end

    // open one request; kind 0 cpu, 1 refresh, 2 dma, 3 refresh and cpu
    task automatic start(input logic [1:0] kind, input logic [23:0] addr,
                         input logic memio);
        @(posedge clock);
        #1;
        address = addr;
        mem_io = memio;
        if (kind == 2'd2) begin
            hold_ack_in = 1'b1;
            // address bit 0 picks read or write, mem_io memory or io
            if (memio) begin
                xbus_mem_read_n = addr[0];
                xbus_mem_write_n = !addr[0];
            end else begin
                xbus_io_read_n = addr[0];
                xbus_io_write = addr[0];
            end
        end else if (kind != 2'd1) begin
            status_n = addr[0] ? 2'b01 : 2'b10;
        end
        if (kind[0]) begin
            refresh_n = 1'b0;
        end
    endtask : start

    // end the request; released lines must not keep their last value
    task automatic stop();
        @(posedge clock);
        #1;
        {refresh_n, status_n, xbus_mem_read_n, xbus_mem_write_n,
         xbus_io_read_n, xbus_io_write, hold_ack_in} = 8'hfc;
        address = ~address;
        mem_io = ~mem_io;
    endtask : stop
endmodule : mcf_cpu_model

// ---- mcf_front_tb.sv ----
// mcf_front_tb: self-checking bench for the clock and cycle front
`timescale 1ns/1ps
module mcf_front_tb;
    logic clock, resetn, controller_reset_in, crystal_in, cfg_write;
    logic [7:0] cfg_data, cfg_value, cas_n, cfg_model;
    logic crystal_out, system_oscillator_out, oscillator_div_twelve_out;
    logic refresh_n, mem_io, xbus_mem_read_n, xbus_mem_write_n;
    logic xbus_io_read_n, xbus_io_write, hold_ack_in;
    logic bios_rom_select_n, io_cycle;
    logic [1:0] status_n;
    logic [23:0] address, a;
    logic [3:0] ras_n;
    logic [31:0] seed;
    int failures, comparisons, cycles;

    // ------------------------------------------------------------
    // clocks: crystal is unrelated in phase to the processor clock
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        crystal_in = 1'b0;
        forever #34.921 crystal_in = ~crystal_in;
    end

    mcf_cpu_model cpu (.clock(clock), .refresh_n(refresh_n),
        .status_n(status_n), .mem_io(mem_io), .address(address),
        .xbus_mem_read_n(xbus_mem_read_n),
        .xbus_mem_write_n(xbus_mem_write_n),
        .xbus_io_read_n(xbus_io_read_n), .xbus_io_write(xbus_io_write),
        .hold_ack_in(hold_ack_in));

    mcf_front dut (.clock(clock), .resetn(resetn),
        .controller_reset_in(controller_reset_in), .crystal_in(crystal_in),
        .crystal_out(crystal_out),
        .system_oscillator_out(system_oscillator_out),
        .oscillator_div_twelve_out(oscillator_div_twelve_out),
        .refresh_n(refresh_n), .status_n(status_n), .mem_io(mem_io),
        .address(address), .xbus_mem_read_n(xbus_mem_read_n),
        .xbus_mem_write_n(xbus_mem_write_n),
        .xbus_io_read_n(xbus_io_read_n), .xbus_io_write(xbus_io_write),
        .hold_ack_in(hold_ack_in), .cfg_write(cfg_write),
        .cfg_data(cfg_data), .cfg_value(cfg_value), .ras_n(ras_n),
        .cas_n(cas_n), .bios_rom_select_n(bios_rom_select_n),
        .io_cycle(io_cycle));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard: the whole run needs a few thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic set_cfg(input logic [7:0] v);
        @(posedge clock);
        #1;
        cfg_write = 1'b1;
        cfg_data = v;
        @(posedge clock);
        #1;
        cfg_write = 1'b0;
        cfg_model = v;
    endtask : set_cfg

    // one request against the reference strobe walk, edge by edge
    task automatic run(input logic [1:0] kind, input logic [23:0] ad,
                       input logic memio);
        logic [3:0] er;
        logic [7:0] ec;
        logic rom, dram, win;
        int b;
        b = ad[22:21];
        win = ad[23:16] == 8'h0f || ad[23:16] == 8'hff;
        rom = kind != 2'd1 && memio && win && !(kind == 2'd2 && ad[0]);
        dram = memio && ad < 24'h800000 && !win && cfg_model[1];
        dram = kind[0] || dram;
        cpu.start(kind, ad, memio);
        for (int k = 1; k <= 16; k++) begin
            @(posedge clock);
            #2;
            er = 4'hf;
            ec = 8'hff;
            if (dram && k >= 3 && k <= 11) begin
                if (kind[0]) er = 4'h0;
                else er[b] = 1'b0;
                if (!kind[0] && k >= 7) ec[2*b +: 2] = 2'b00;
            end
            check(ras_n, er);
            check(cas_n, ec);
            check(bios_rom_select_n, !(rom && cfg_model[0] && k >= 3));
            if (k >= 4) check(io_cycle, !kind[0] && !memio);
            check(crystal_out, !system_oscillator_out);
        end
        cpu.stop();
        repeat (6) @(posedge clock);
        #2;
        check(bios_rom_select_n, 1'b1);
    endtask : run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n, rises;
        logic po, pd, started;
        resetn = 1'b0;
        controller_reset_in = 1'b0;
        cfg_write = 1'b0;
        cfg_data = 8'h00;
        cfg_model = 8'h03;
        seed = 32'h53575243;
        repeat (16) @(posedge clock);
        #1;
        check(system_oscillator_out, 1'b0);
        resetn = 1'b1;
        repeat (4) @(posedge clock);
        #2;
        check(cfg_value, 8'h03);
        // random dram cycles over banks 0 to 3, then the boundaries
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            a = {1'b0, seed[22:0]};
            if (a[23:16] == 8'h0f) a[16] = 1'b0;
            run(2'd0, a, 1'b1);
        end
        run(2'd0, 24'h7fffff, 1'b1);
        run(2'd0, 24'h800000, 1'b1);
        run(2'd0, seed[23:0], 1'b0);
        run(2'd0, 24'h0f1234, 1'b1);
        run(2'd0, 24'hff0000, 1'b1);
        run(2'd1, seed[23:0], 1'b1);
        run(2'd2, {1'b0, seed[30:8]}, 1'b1);
        run(2'd2, 24'h0f0000, 1'b1);
        run(2'd2, 24'h600001, 1'b1);
        run(2'd2, 24'h000000, 1'b0);
        run(2'd2, 24'h000001, 1'b0);
        run(2'd3, 24'h123456, 1'b1);
        // both enables cleared: cpu and rom blocked, refresh still runs
        set_cfg(8'h00);
        run(2'd0, 24'h200000, 1'b1);
        run(2'd0, 24'h0f0000, 1'b1);
        run(2'd1, 24'h000000, 1'b1);
        // controller reset pin restores defaults and parks outputs
        @(posedge clock);
        #1;
        controller_reset_in = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        check(cfg_value, 8'h03);
        check({ras_n, cas_n}, 12'hfff);
        check(system_oscillator_out, 1'b0);
        check(oscillator_div_twelve_out, 1'b0);
        controller_reset_in = 1'b0;
        cfg_model = 8'h03;
        repeat (5) @(posedge clock);
        // oscillator rises between divider toggles, and overall rate
        n = 0;
        rises = 0;
        started = 1'b0;
        po = system_oscillator_out;
        pd = oscillator_div_twelve_out;
        for (int c = 0; c < 1500; c++) begin
            @(posedge clock);
            #2;
            if (oscillator_div_twelve_out !== pd) begin
                if (started) check(n, 6);
                n = 0;
                started = 1'b1;
            end
            if (system_oscillator_out && !po) begin
                n++;
                rises++;
            end
            po = system_oscillator_out;
            pd = oscillator_div_twelve_out;
        end
        check(rises >= 171 && rises <= 172, 1'b1);
        tally_and_finish();
    end
endmodule : mcf_front_tb
